// ---- acr_cal_seq.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "acr_params.svh"
module acr_cal_seq
  import acr_pkg::*;
#(
  parameter int FG_CYCLES = (`ACR_FG_CAL_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cal_enable,
  input wire acr_cal_type cfg,
  output logic cal_values_clear,
  output logic fg_running,
  output logic foreground_done_flag,
  output logic bg_running
);

  typedef enum logic [3:0] {
    acr_st_idle = 4'b0001,
    acr_st_clear = 4'b0010,
    acr_st_fg = 4'b0100,
    acr_st_done = 4'b1000
  } acr_state_type;

  acr_state_type state_q, state_d;
  logic [15:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      acr_st_idle: if (cal_enable) state_d = acr_st_clear;
      acr_st_clear: begin
        cnt_d = 16'h0000;
        state_d = cfg.foreground_cal_run ? acr_st_fg : acr_st_done;
      end
      acr_st_fg: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(FG_CYCLES - 1)) state_d = acr_st_done;
      end
      acr_st_done: state_d = acr_st_done;
      default: state_d = acr_st_idle;
    endcase
    if (!cal_enable) state_d = acr_st_idle;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= acr_st_idle;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign cal_values_clear = (state_q == acr_st_clear);
  assign fg_running = (state_q == acr_st_fg);
  assign foreground_done_flag = (state_q == acr_st_done);
  // background only in the done state, after the foreground phase, or straight after the clear if no foreground run is set
  assign bg_running = foreground_done_flag && cfg.background_cal_enable;

endmodule // acr_cal_seq
`default_nettype wire

// ---- acr_params.svh ----
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_OFS_SWING 12'h048
`define ACR_OFS_ROUTE 12'h060
`define ACR_OFS_CAL_EN 12'h061
`define ACR_OFS_CAL_CFG 12'h062

`define ACR_RST_SWING 8'h00
`define ACR_RST_ROUTE 8'h01
`define ACR_RST_CAL_EN 8'h01
`define ACR_RST_CAL_CFG 8'h01

`define ACR_BIT_DUAL_SWAP 4
`define ACR_BIT_CAL_EN 0
`define ACR_BIT_BG_OS 3
`define ACR_BIT_FG_OS 2
`define ACR_BIT_BG 1
`define ACR_BIT_FG 0

`define ACR_SWING_HIGH 2'h0
`define ACR_SWING_LOW 2'h1
`define ACR_SWING_HIZ 2'h3
`define ACR_SEL_A 2'h1
`define ACR_SEL_B 2'h2

`define ACR_FG_CAL_NS 3000
`define ACR_CLK_NS 100

`endif

// ---- acr_pkg.sv ----
package acr_pkg;

  typedef enum logic [1:0] {
    acr_swing_high_type_v = 2'h0,
    acr_swing_low_type_v = 2'h1,
    acr_swing_rsvd_type_v = 2'h2,
    acr_swing_hiz_type_v = 2'h3
  } acr_swing_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } acr_req_type;

  typedef struct packed {
    logic high_swing;
    logic low_swing;
    logic low_swing_high_impedance;
  } acr_drv_type;

  typedef struct packed {
    logic background_offset_cal_enable;
    logic foreground_offset_cal_enable;
    logic background_cal_enable;
    logic foreground_cal_run;
  } acr_cal_type;

endpackage

// ---- acr_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "acr_params.svh"
module acr_regs
  import acr_pkg::*;
#(
  parameter int FG_CYCLES = (`ACR_FG_CAL_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire acr_req_type req,
  input wire logic interleave_enable,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output acr_drv_type drv_q,
  output logic swap_q,
  output logic sample_a_q,
  output logic sample_b_q,
  output logic interleave_on_input_a_q,
  output logic interleave_on_input_b_q,
  output logic divider_reset_q,
  output logic cal_reset_q,
  output logic cal_values_clear_q,
  output logic fg_running_q,
  output logic bg_running_q,
  output logic fg_offset_active_q,
  output logic bg_offset_active_q,
  output logic foreground_done_flag_q
);

  logic [7:0] swing_q, swing_d;
  logic [7:0] route_q, route_d;
  logic [7:0] calen_q, calen_d;
  logic [7:0] calcfg_q, calcfg_d;
  logic [7:0] rdata_d;
  logic rvalid_d;
  acr_cal_type cfg;
  logic seq_clear, seq_fg, seq_done, seq_bg;

  // reserved bits are plain storage, no decoder looks at them
  always_comb begin
    swing_d = swing_q;
    route_d = route_q;
    calen_d = calen_q;
    calcfg_d = calcfg_q;
    if (req.wr) begin
      case (req.addr)
        `ACR_OFS_SWING: swing_d = req.wdata;
        `ACR_OFS_ROUTE: route_d = req.wdata;
        `ACR_OFS_CAL_EN: calen_d = req.wdata;
        // write accepted regardless; ordering is software's job
        `ACR_OFS_CAL_CFG: calcfg_d = req.wdata;
        default: swing_d = swing_q;
      endcase
    end
  end

  always_comb begin
    rvalid_d = req.rd;
    case (req.addr)
      `ACR_OFS_SWING: rdata_d = swing_q;
      `ACR_OFS_ROUTE: rdata_d = route_q;
      `ACR_OFS_CAL_EN: rdata_d = calen_q;
      `ACR_OFS_CAL_CFG: rdata_d = calcfg_q;
      default: rdata_d = 8'h00;
    endcase
    if (!req.rd) rdata_d = 8'h00;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      swing_q <= `ACR_RST_SWING;
      route_q <= `ACR_RST_ROUTE;
      calen_q <= `ACR_RST_CAL_EN;
      calcfg_q <= `ACR_RST_CAL_CFG;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      swing_q <= swing_d;
      route_q <= route_d;
      calen_q <= calen_d;
      calcfg_q <= calcfg_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cfg.background_offset_cal_enable = calcfg_q[`ACR_BIT_BG_OS];
  assign cfg.foreground_offset_cal_enable = calcfg_q[`ACR_BIT_FG_OS];
  assign cfg.background_cal_enable = calcfg_q[`ACR_BIT_BG];
  assign cfg.foreground_cal_run = calcfg_q[`ACR_BIT_FG];

  acr_cal_seq #(
    .FG_CYCLES(FG_CYCLES)
  ) u_seq (
    .clock(clock),
    .reset_n(reset_n),
    .cal_enable(calen_q[`ACR_BIT_CAL_EN]),
    .cfg(cfg),
    .cal_values_clear(seq_clear),
    .fg_running(seq_fg),
    .foreground_done_flag(seq_done),
    .bg_running(seq_bg)
  );

  acr_drv_type drv_d;
  logic swap_d, sa_d, sb_d, ia_d, ib_d;

  always_comb begin
    drv_d = '0;
    // reserved code 2 drives nothing rather than guess a mode
    case (swing_q[1:0])
      `ACR_SWING_HIGH: drv_d.high_swing = 1'b1;
      `ACR_SWING_LOW: drv_d.low_swing = 1'b1;
      `ACR_SWING_HIZ: drv_d.low_swing_high_impedance = 1'b1;
      default: drv_d = '0;
    endcase
    swap_d = !interleave_enable && route_q[`ACR_BIT_DUAL_SWAP];
    sa_d = !interleave_enable;
    sb_d = !interleave_enable;
    ia_d = interleave_enable && (route_q[1:0] == `ACR_SEL_A);
    ib_d = interleave_enable && (route_q[1:0] == `ACR_SEL_B);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drv_q <= '0;
      swap_q <= 1'b0;
      sample_a_q <= 1'b0;
      sample_b_q <= 1'b0;
      interleave_on_input_a_q <= 1'b0;
      interleave_on_input_b_q <= 1'b0;
      divider_reset_q <= 1'b1;
      cal_reset_q <= 1'b1;
      cal_values_clear_q <= 1'b0;
      fg_running_q <= 1'b0;
      bg_running_q <= 1'b0;
      fg_offset_active_q <= 1'b0;
      bg_offset_active_q <= 1'b0;
      foreground_done_flag_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      swap_q <= swap_d;
      sample_a_q <= sa_d;
      sample_b_q <= sb_d;
      interleave_on_input_a_q <= ia_d;
      interleave_on_input_b_q <= ib_d;
      divider_reset_q <= !calen_q[`ACR_BIT_CAL_EN];
      cal_reset_q <= !calen_q[`ACR_BIT_CAL_EN];
      // gated by the enable so activity drops in the same cycle as the hold
      cal_values_clear_q <= seq_clear && calen_q[`ACR_BIT_CAL_EN];
      fg_running_q <= seq_fg && calen_q[`ACR_BIT_CAL_EN];
      bg_running_q <= seq_bg && calen_q[`ACR_BIT_CAL_EN];
      fg_offset_active_q <= seq_fg && calen_q[`ACR_BIT_CAL_EN] && cfg.foreground_offset_cal_enable
        && cfg.foreground_cal_run;
      bg_offset_active_q <= seq_bg && calen_q[`ACR_BIT_CAL_EN] && cfg.background_offset_cal_enable;
      foreground_done_flag_q <= seq_done && calen_q[`ACR_BIT_CAL_EN];
    end
  end

endmodule // acr_regs
`default_nettype wire

// ---- acr_regs_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module acr_regs_checker
  import acr_pkg::*;
#(
  parameter int FG_CYCLES = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire acr_req_type req,
  input wire logic interleave_enable,
  input wire logic rvalid_q,
  input wire acr_drv_type drv_q,
  input wire logic swap_q,
  input wire logic interleave_on_input_a_q,
  input wire logic interleave_on_input_b_q,
  input wire logic divider_reset_q,
  input wire logic cal_reset_q,
  input wire logic cal_values_clear_q,
  input wire logic fg_running_q,
  input wire logic bg_running_q,
  input wire logic fg_offset_active_q,
  input wire logic bg_offset_active_q,
  input wire logic foreground_done_flag_q
);
  int run_q;
  int run_d;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // length of the current foreground run
  always_comb run_d = fg_running_q ? run_q + 1 : 0;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) run_q <= 0;
    else run_q <= run_d;
  end
  chk_read_valid: assert property (req.rd |=> rvalid_q) else $error("read not answered");
  chk_swing_decode: assert property (req.wr && req.addr == 12'h048 |-> ##2 drv_q ==
    {$past(req.wdata[1:0], 2) == 2'h0, $past(req.wdata[1:0], 2) == 2'h1, $past(req.wdata[1:0], 2) == 2'h3})
    else $error("swing decode wrong");
  chk_swap_dual: assert property (req.wr && req.addr == 12'h060 && !interleave_enable ##1 !interleave_enable
    |=> swap_q == $past(req.wdata[4], 2)) else $error("swap wrong");
  chk_swap_ignored: assert property (interleave_enable |=> !swap_q) else $error("swap in interleave");
  chk_sel_field: assert property (req.wr && req.addr == 12'h060 && interleave_enable ##1 interleave_enable
    |=> {interleave_on_input_a_q, interleave_on_input_b_q} ==
    {$past(req.wdata[1:0], 2) == 2'h1, $past(req.wdata[1:0], 2) == 2'h2}) else $error("select wrong");
  chk_sel_ignored: assert property (!interleave_enable |=> !interleave_on_input_a_q && !interleave_on_input_b_q)
    else $error("select in dual");
  chk_cal_hold: assert property (req.wr && req.addr == 12'h061 |-> ##2 divider_reset_q == !$past(req.wdata[0], 2))
    else $error("hold wrong");
  chk_div_pair: assert property (divider_reset_q == cal_reset_q) else $error("dividers not held");
  chk_hold_idle: assert property (divider_reset_q |-> !fg_running_q && !foreground_done_flag_q)
    else $error("active in hold");
  chk_clear_pulse: assert property (cal_values_clear_q |=> !cal_values_clear_q) else $error("clear not pulse");
  chk_fg_length: assert property ($fell(fg_running_q) && !cal_reset_q |-> run_q == FG_CYCLES)
    else $error("fg length wrong");
  chk_bg_offset: assert property (bg_offset_active_q |-> bg_running_q) else $error("bg offset alone");
  chk_fg_offset: assert property (fg_offset_active_q |-> fg_running_q) else $error("fg offset alone");
  chk_done_cause: assert property ($rose(foreground_done_flag_q) |-> $past(fg_running_q) ||
    $past(fg_running_q, 2) || $past(cal_values_clear_q) || $past(cal_values_clear_q, 2)) else $error("done uncaused");
endmodule // acr_regs_checker
bind acr_regs acr_regs_checker #(.FG_CYCLES(FG_CYCLES)) u_chk (.clock, .reset_n, .req, .interleave_enable,
  .rvalid_q, .drv_q, .swap_q, .interleave_on_input_a_q, .interleave_on_input_b_q, .divider_reset_q, .cal_reset_q,
  .cal_values_clear_q, .fg_running_q, .bg_running_q, .fg_offset_active_q, .bg_offset_active_q, .foreground_done_flag_q);
`default_nettype wire

// ---- acr_regs_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module acr_regs_tb_top;
  import acr_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  acr_req_type req = '0;
  logic interleave_enable = 0;
  logic [7:0] rdata_q;
  acr_drv_type drv_q;
  logic rvalid_q, swap_q, sample_a_q, sample_b_q, interleave_on_input_a_q, interleave_on_input_b_q;
  logic divider_reset_q, cal_reset_q, cal_values_clear_q, fg_running_q, bg_running_q;
  logic fg_offset_active_q, bg_offset_active_q, foreground_done_flag_q;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // {interleave, routing value, swap, on a, on b}
  logic [11:0] rt [6] = '{12'h084, 12'h88a, 12'h811, 12'h800, 12'h010, 12'h898};
  logic [7:0] cf [5] = '{8'h01, 8'h0e, 8'h05, 8'h0b, 8'hf4};
  // short foreground run keeps the bench quick
  acr_regs #(.FG_CYCLES(4)) u_dut (.clock, .reset_n, .req, .interleave_enable, .rdata_q, .rvalid_q, .drv_q,
    .swap_q, .sample_a_q, .sample_b_q, .interleave_on_input_a_q, .interleave_on_input_b_q, .divider_reset_q,
    .cal_reset_q, .cal_values_clear_q, .fg_running_q, .bg_running_q, .fg_offset_active_q, .bg_offset_active_q,
    .foreground_done_flag_q);
  initial forever #50 clock = ~clock;
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // returns after the edge that updates derived outputs
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    req = '0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clock);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    req = '0;
    chk("rvalid", 8'h01, {7'h00, rvalid_q});
    chk("rdata", e, rdata_q);
  endtask
  // settings only change with calibration held, as software must
  // no output interface enable here, so bring-up and shutdown order is not driven
  task automatic run_cal(input logic [7:0] c);
    int f;
    int fo;
    wr(12'h061, 8'h00);
    chk("hold", 8'h03, {6'h00, divider_reset_q, cal_reset_q});
    chk("flag_off", 8'h00, {7'h00, foreground_done_flag_q});
    wr(12'h062, c);
    wr(12'h061, 8'h01);
    f = 0;
    fo = 0;
    for (int i = 0; i < 40 && foreground_done_flag_q !== 1'b1; i++) begin
      @(negedge clock);
      f += int'(fg_running_q === 1'b1);
      fo += int'(fg_offset_active_q === 1'b1);
    end
    chk("fg_len", c[0] ? 8'h04 : 8'h00, f[7:0]);
    chk("fg_os_len", c[0] && c[2] ? 8'h04 : 8'h00, fo[7:0]);
    repeat (2) @(negedge clock);
    chk("done", 8'h01, {7'h00, foreground_done_flag_q});
    chk("bg", {6'h00, c[1], c[1] & c[3]}, {6'h00, bg_running_q, bg_offset_active_q});
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1;
    rd(12'h048, 8'h00);
    rd(12'h060, 8'h01);
    rd(12'h061, 8'h01);
    rd(12'h062, 8'h01);
    rd(12'h123, 8'h00);
    chk("boot_done", 8'h01, {7'h00, foreground_done_flag_q});
    // code 3 only decoded here, no line length modelled
    for (int k = 0; k < 4; k++) begin
      wr(12'h048, {6'h3f, k[1:0]});
      chk("drv", {5'h00, k == 0, k == 1, k == 3}, {5'h00, drv_q});
      rd(12'h048, {6'h3f, k[1:0]});
    end
    foreach (rt[j]) begin
      interleave_enable = rt[j][11];
      wr(12'h060, rt[j][10:3]);
      chk("route", {5'h00, rt[j][2:0]}, {5'h00, swap_q, interleave_on_input_a_q, interleave_on_input_b_q});
    end
    foreach (cf[j]) run_cal(cf[j]);
    rd(12'h062, 8'hf4);
    give_verdict();
  end
endmodule // acr_regs_tb_top
`default_nettype wire
